/* File: common/umm_pkg.sv */
// Package of address map constants and types for the unified memory map decoder.
package umm_pkg;

  // ************************************************************
  // Address map boundaries.
  // ************************************************************
  localparam int ADDR_W = 24;
  localparam logic [23:0] FLASH_REGS_BASE = 24'hff_ff00;
  localparam logic [23:0] TRAP_HI_BASE = 24'hf0_0000;
  localparam logic [23:0] EMU_PROG_MIRROR_BASE = 24'he9_0000;
  localparam logic [23:0] EMU_PROG_BASE = 24'he8_0000;
  localparam logic [23:0] PROG_SRAM_MIRROR_BASE = 24'he1_0000;
  localparam logic [23:0] PROG_SRAM_BASE = 24'he0_0000;
  localparam logic [23:0] PROG_RSVD_BASE = 24'hcc_0000;
  localparam logic [23:0] FLASH_BASE = 24'hc0_0000;
  localparam logic [23:0] EXT_MEM_HI_BASE = 24'h40_0000;
  localparam logic [23:0] EXT_IO_BASE = 24'h20_5800;
  localparam logic [23:0] SER_LX_BASE = 24'h20_4000;
  localparam logic [23:0] CAN_LX_BASE = 24'h20_0000;
  localparam logic [23:0] EXT_MEM_MID_BASE = 24'h01_0000;
  localparam logic [23:0] FUNC_REGS_BASE = 24'h00_fe00;
  localparam logic [23:0] DUAL_RAM_BASE = 24'h00_f600;
  localparam logic [23:0] DUAL_RAM_BIT_BASE = 24'h00_fd00;
  localparam logic [23:0] DUAL_RAM_RSVD_BASE = 24'h00_f200;
  localparam logic [23:0] EXT_REGS_BASE = 24'h00_f000;
  localparam logic [23:0] PERIPH_REGS_BASE = 24'h00_e000;
  localparam logic [23:0] DATA_SRAM_BASE = 24'h00_a000;
  localparam logic [23:0] DATA_SRAM_RSVD_BASE = 24'h00_8000;
  // Standby memory window, placed inside the high trap area.
  localparam logic [23:0] STANDBY_BASE = 24'hf0_0000;
  localparam logic [23:0] STANDBY_END = 24'hf0_03ff;
  // Reserved flash sector for operation control and protection data.
  localparam logic [11:0] FLASH_RSVD_SECTOR = 12'hc0f;

  // ************************************************************
  // Segment, page, flash and register bank geometry.
  // ************************************************************
  localparam int SEG_W = 8;
  localparam int PAGE_W = 2;
  localparam int FLASH_MODULES = 3;
  localparam int FLASH_SECTORS = 64;
  localparam int FLASH_GROUP_SECTORS = 4;
  localparam int FLASH_GROUPS = FLASH_SECTORS / FLASH_GROUP_SECTORS;
  localparam int FLASH_PROG_BLOCK = 128;
  localparam int FLASH_LINE_BYTES = 16;
  localparam int BANK_REGS = 16;
  localparam int BANK_BYTE_REGS = 8;

  // Target regions of the map.
  typedef enum logic [3:0] {
    UMM_EXT_MEM, UMM_EXT_IO, UMM_LX_CAN, UMM_LX_SER, UMM_FLASH, UMM_PROG_SRAM, UMM_EMU_PROG,
    UMM_FLASH_REGS, UMM_STANDBY, UMM_DATA_SRAM, UMM_PERIPH_REGS, UMM_EXT_REGS, UMM_DUAL_RAM, UMM_FUNC_REGS,
    UMM_TRAP
  } umm_region_e;

  // One decoded access result.
  typedef struct packed {
    logic valid;
    umm_region_e region;
    logic sysbus;
    logic trap;
    logic reject;
    logic ordered;
    logic bit_ok;
    logic bank_hit;
    logic [3:0] bank_idx;
    logic [1:0] flash_mod;
    logic [19:0] flash_line;
    logic [7:0] segment;
    logic [1:0] page;
    logic [15:0] offset;
    logic word;
  } umm_res_s;

endpackage : umm_pkg

/* File: core/umm_decoder.sv */
// Unified memory map decoder routing code fetches and data transfers.

module umm_decoder #(
  parameter int NUM_FLASH = umm_pkg::FLASH_MODULES
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Instruction fetch request.
  input wire logic f_req,
  input wire logic [umm_pkg::ADDR_W-1:0] f_addr,
  input wire logic f_word,
  // Data transfer request.
  input wire logic d_req,
  input wire logic [umm_pkg::ADDR_W-1:0] d_addr,
  input wire logic d_word,
  input wire logic d_write,
  // Protection and context controls.
  input wire logic [umm_pkg::ADDR_W-1:0] ctx_ptr,
  input wire logic ps_wp_en,
  input wire logic [15:0] ps_wp_size,
  input wire logic [umm_pkg::FLASH_MODULES*umm_pkg::FLASH_GROUPS-1:0] fl_wp_mask,
  input wire logic fl_rp_en,
  input wire logic fl_unlock,
  // Fetch result toward the program unit.
  output umm_pkg::umm_res_s f_res,
  // Data result toward the data unit.
  output umm_pkg::umm_res_s d_res,
  output logic d_write_q,
  // Flash module conflict between the two channels.
  output logic fl_clash
);
  import umm_pkg::*;

  // ************************************************************
  // State.
  // ************************************************************
  typedef struct packed {
    umm_res_s f;
    umm_res_s d;
    logic d_wr;
    logic clash;
  } umm_state_s;

  umm_state_s state_q;
  umm_state_s state_d;

  // Region lookup from the full address.
  // map lookup
  function automatic umm_region_e umm_lookup(input logic [23:0] a);
    umm_region_e r;
    r = UMM_TRAP;
    if (a >= FLASH_REGS_BASE)
      r = UMM_FLASH_REGS;
    else if (a >= STANDBY_BASE && a <= STANDBY_END)
      r = UMM_STANDBY;
    else if (a >= TRAP_HI_BASE)
      r = UMM_TRAP;
    else if (a >= EMU_PROG_BASE)
      r = UMM_EMU_PROG;
    else if (a >= PROG_SRAM_BASE)
      r = UMM_PROG_SRAM;
    else if (a >= PROG_RSVD_BASE)
      r = UMM_TRAP;
    else if (a >= FLASH_BASE)
      r = (a[19:18] < 2'(NUM_FLASH)) ? UMM_FLASH : UMM_TRAP;
    else if (a >= EXT_MEM_HI_BASE)
      r = UMM_EXT_MEM;
    else if (a >= EXT_IO_BASE)
      r = UMM_EXT_IO;
    else if (a >= SER_LX_BASE)
      r = UMM_LX_SER;
    else if (a >= CAN_LX_BASE)
      r = UMM_LX_CAN;
    else if (a >= EXT_MEM_MID_BASE)
      r = UMM_EXT_MEM;
    else if (a >= FUNC_REGS_BASE)
      r = UMM_FUNC_REGS;
    else if (a >= DUAL_RAM_BASE)
      r = UMM_DUAL_RAM;
    else if (a >= DUAL_RAM_RSVD_BASE)
      r = UMM_TRAP;
    else if (a >= EXT_REGS_BASE)
      r = UMM_EXT_REGS;
    else if (a >= PERIPH_REGS_BASE)
      r = UMM_PERIPH_REGS;
    else if (a >= DATA_SRAM_BASE)
      r = UMM_DATA_SRAM;
    else if (a >= DATA_SRAM_RSVD_BASE)
      r = UMM_TRAP;
    else
      r = UMM_EXT_MEM;
    return r;
  endfunction : umm_lookup

  // True for memories owned by the program unit.
  function automatic logic umm_prog_mem(input umm_region_e r);
    return (r == UMM_FLASH) || (r == UMM_PROG_SRAM) || (r == UMM_EMU_PROG);
  endfunction : umm_prog_mem

  // True for targets reached over the external or internal peripheral bus.
  function automatic logic umm_bus_side(input umm_region_e r);
    return (r == UMM_EXT_MEM) || (r == UMM_EXT_IO) || (r == UMM_LX_CAN) || (r == UMM_LX_SER);
  endfunction : umm_bus_side

  // Common decode of one access into its result fields.
  function automatic umm_res_s umm_decode(input logic req, input logic [23:0] a, input logic w,
                                          input logic [23:0] cp);
    umm_res_s res;
    logic [23:0] gofs;
    res = '0;
    gofs = a - cp;
    res.valid = req;
    res.region = umm_lookup(a);
    res.segment = a[23:16];
    res.page = a[15:14];
    res.offset = a[15:0];
    res.word = w;
    res.trap = req && (res.region == UMM_TRAP);
    res.ordered = (res.region == UMM_EXT_IO);
    res.bit_ok = (res.region == UMM_FUNC_REGS) || (res.region == UMM_EXT_REGS)
                 || (a >= DUAL_RAM_BIT_BASE && a < FUNC_REGS_BASE);
    res.bank_hit = (res.region == UMM_DUAL_RAM) && (a >= cp) && (gofs < 24'(2 * BANK_REGS));
    res.bank_idx = gofs[4:1];
    if (res.bank_hit)
      res.bit_ok = 1'b1;
    if (!w && res.bank_hit && gofs[4:1] >= 4'(BANK_BYTE_REGS))
      res.bank_hit = 1'b0;
    res.flash_mod = a[19:18];
    res.flash_line = a[23:4];
    return res;
  endfunction : umm_decode

  logic [23:0] d_wp_ofs;
  logic [5:0] d_sector;
  logic d_grp_prot;
  umm_res_s f_now;
  umm_res_s d_now;

  // ************************************************************
  // Next state.
  // ************************************************************

  // Decode both channels side by side so they proceed in the same cycle.
  always_comb
  begin
    state_d = state_q;
    f_now = umm_decode(f_req, f_addr, f_word, ctx_ptr);
    d_now = umm_decode(d_req, d_addr, d_word, ctx_ptr);
    d_wp_ofs = {8'h00, d_addr[15:0]};
    d_sector = d_addr[17:12];
    d_grp_prot = fl_wp_mask[{d_addr[19:18], d_sector[5:2]}];
    f_now.sysbus = f_req && !f_now.trap && !umm_prog_mem(f_now.region);
    d_now.sysbus = d_req && !d_now.trap && (umm_prog_mem(d_now.region) || umm_bus_side(d_now.region));
    if (d_req && d_write && ps_wp_en && (d_now.region == UMM_PROG_SRAM || d_now.region == UMM_EMU_PROG)
        && d_wp_ofs < {8'h00, ps_wp_size})
      d_now.reject = 1'b1;
    if (d_req && d_write && d_now.region == UMM_FLASH && d_addr[23:12] == FLASH_RSVD_SECTOR)
      d_now.reject = 1'b1;
    if (d_req && d_write && d_now.region == UMM_FLASH && d_grp_prot)
      d_now.reject = 1'b1;
    if (d_req && !d_write && d_now.region == UMM_FLASH && fl_rp_en && !fl_unlock)
      d_now.reject = 1'b1;
    if (d_now.trap)
      d_now.sysbus = 1'b0;
    state_d.f = f_now;
    state_d.d = d_now;
    state_d.d_wr = d_req && d_write;
    state_d.clash = f_req && d_req && f_now.region == UMM_FLASH && d_now.region == UMM_FLASH
                    && f_now.flash_mod == d_now.flash_mod;
  end

  // Register the whole state.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  // Results come straight from the state flops.
  assign f_res = state_q.f;
  assign d_res = state_q.d;
  assign d_write_q = state_q.d_wr;
  assign fl_clash = state_q.clash;

  // ************************************************************
  // Assertions.
  // ************************************************************
  sequence f_hits_dual_ram;
    f_req && f_addr >= DUAL_RAM_BASE && f_addr < FUNC_REGS_BASE;
  endsequence

  sequence d_wp_write;
    d_req && d_write && ps_wp_en && d_addr[23:16] == PROG_SRAM_BASE[23:16] && d_addr[15:0] < ps_wp_size;
  endsequence

  segment_split_a: assert property (@(posedge sys_clk) disable iff (rst)
    d_req |=> d_res.segment == $past(d_addr[23:16]) && d_res.page == $past(d_addr[15:14]))
    else $error("segment or page split wrong");

  sys_segment_a: assert property (@(posedge sys_clk) disable iff (rst)
    d_res.valid && (d_res.region == UMM_FUNC_REGS || d_res.region == UMM_DATA_SRAM || d_res.region == UMM_DUAL_RAM)
    |-> d_res.segment == 8'h00)
    else $error("internal memory outside segment zero");

  fetch_route_a: assert property (@(posedge sys_clk) disable iff (rst)
    f_hits_dual_ram |=> f_res.valid && f_res.sysbus && f_res.region == UMM_DUAL_RAM)
    else $error("fetch from data memory not sent over system bus");

  data_cross_a: assert property (@(posedge sys_clk) disable iff (rst)
    d_req && d_addr >= CAN_LX_BASE && d_addr < SER_LX_BASE |=> d_res.sysbus && d_res.region == UMM_LX_CAN)
    else $error("peripheral bus access not crossing");

  prog_wp_a: assert property (@(posedge sys_clk) disable iff (rst)
    d_wp_write |=> d_res.reject && d_write_q)
    else $error("protected program sram write accepted");

  rsvd_sector_a: assert property (@(posedge sys_clk) disable iff (rst)
    d_req && d_write && d_addr[23:12] == FLASH_RSVD_SECTOR |=> d_res.reject)
    else $error("write to reserved flash sector accepted");

  flash_rp_a: assert property (@(posedge sys_clk) disable iff (rst)
    d_req && !d_write && fl_rp_en && !fl_unlock && d_addr[23:18] == FLASH_BASE[23:18]
    |=> d_res.reject || d_res.trap)
    else $error("protected flash read not rejected");

  io_order_a: assert property (@(posedge sys_clk) disable iff (rst)
    d_req && d_addr >= EXT_IO_BASE && d_addr < EXT_MEM_HI_BASE |=> d_res.ordered)
    else $error("external io access not ordered");

  trap_raise_a: assert property (@(posedge sys_clk) disable iff (rst)
    d_req && d_addr >= DATA_SRAM_RSVD_BASE && d_addr < DATA_SRAM_BASE |=> d_res.trap && !d_res.sysbus)
    else $error("reserved area did not trap");

  dual_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
    d_req && d_addr >= DUAL_RAM_BIT_BASE && d_addr < FUNC_REGS_BASE |=> d_res.bit_ok)
    else $error("top dual port bytes not bit addressable");

endmodule : umm_decoder

/* File: tb/testbench.sv */
// Self-checking testbench for the unified memory map decoder.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import umm_pkg::*;

  // ************************************************************
  // Signals, clock and instances.
  // ************************************************************
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic f_req, f_word, d_req, d_word, d_write, d_write_q, fl_clash;
  logic [ADDR_W-1:0] f_addr, d_addr;
  logic [ADDR_W-1:0] ctx_ptr = 24'h00_fc00;
  logic ps_wp_en = 1'b0;
  logic [15:0] ps_wp_size = 16'h0100;
  logic [FLASH_MODULES*FLASH_GROUPS-1:0] fl_wp_mask = '0;
  logic fl_rp_en = 1'b0;
  logic fl_unlock = 1'b0;
  umm_res_s f_res, d_res;
  int failures = 0;
  int checks_done = 0;

  // Clock of 20 ns period.
  always #10 sys_clk = ~sys_clk;

  umm_core_model core_inst (.sys_clk(sys_clk), .f_req(f_req), .f_addr(f_addr), .f_word(f_word),
    .d_req(d_req), .d_addr(d_addr), .d_word(d_word), .d_write(d_write));
  umm_decoder umm_decoder_inst (.sys_clk(sys_clk), .rst(rst), .f_req(f_req), .f_addr(f_addr),
    .f_word(f_word), .d_req(d_req), .d_addr(d_addr), .d_word(d_word), .d_write(d_write),
    .ctx_ptr(ctx_ptr), .ps_wp_en(ps_wp_en), .ps_wp_size(ps_wp_size), .fl_wp_mask(fl_wp_mask),
    .fl_rp_en(fl_rp_en), .fl_unlock(fl_unlock), .f_res(f_res), .d_res(d_res),
    .d_write_q(d_write_q), .fl_clash(fl_clash));

  // ************************************************************
  // Shared checks and the closing report.
  // ************************************************************
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // ************************************************************
  // Scenarios.
  // ************************************************************
  // Walks region boundaries on the data channel and checks the decoded fields.
  task automatic t_map();
    logic [23:0] a [22] = '{24'h00_7fff, 24'h00_8000, 24'h00_a000, 24'h00_dfff, 24'h00_e000,
      24'h00_f1ff, 24'h00_f200, 24'h00_f600, 24'h00_fe00, 24'h00_ffff, 24'h1f_ffff, 24'h20_3fff,
      24'h20_4000, 24'h20_5800, 24'hbf_ffff, 24'hcb_ffff, 24'hcc_0000, 24'he7_fffe, 24'he8_0000,
      24'hf0_03ff, 24'hf0_0400, 24'hff_ff00};
    umm_region_e r [22] = '{UMM_EXT_MEM, UMM_TRAP, UMM_DATA_SRAM, UMM_DATA_SRAM, UMM_PERIPH_REGS,
      UMM_EXT_REGS, UMM_TRAP, UMM_DUAL_RAM, UMM_FUNC_REGS, UMM_FUNC_REGS, UMM_EXT_MEM, UMM_LX_CAN,
      UMM_LX_SER, UMM_EXT_IO, UMM_EXT_MEM, UMM_FLASH, UMM_TRAP, UMM_PROG_SRAM, UMM_EMU_PROG, UMM_STANDBY,
      UMM_TRAP, UMM_FLASH_REGS};
    for (int i = 0; i < 22; i++)
    begin
      core_inst.access(1'b0, 24'h0, 1'b0, 1'b1, a[i], 1'b1, 1'b0);
      chk("valid", 24'h1, 24'(d_res.valid));
      chk("region", 24'(r[i]), 24'(d_res.region));
      chk("trap", 24'(r[i] == UMM_TRAP), 24'(d_res.trap));
      chk("segment", 24'(a[i][23:16]), 24'(d_res.segment));
      chk("page", 24'(a[i][15:14]), 24'(d_res.page));
      chk("offset", 24'(a[i][15:0]), 24'(d_res.offset));
      chk("ordered", 24'(r[i] == UMM_EXT_IO), 24'(d_res.ordered));
    end
  endtask : t_map

  // Routes fetches and data transfers and checks use of the system bus.
  task automatic t_route();
    logic [23:0] a [8] = '{24'hc0_0100, 24'he0_0000, 24'h00_f600, 24'h40_0000, 24'hc0_0100,
      24'h00_a000, 24'he0_0010, 24'h20_4000};
    logic [7:0] isf = 8'b0000_1111;
    logic [7:0] wr = 8'b0100_0000;
    logic [7:0] bus = 8'b1101_1100;
    umm_res_s r;
    for (int i = 0; i < 8; i++)
    begin
      core_inst.access(isf[i], a[i], 1'b1, !isf[i], a[i], 1'b1, wr[i]);
      r = isf[i] ? f_res : d_res;
      chk("sysbus", 24'(bus[i]), 24'(r.sysbus));
      chk("idle valid", 24'h0, 24'(isf[i] ? d_res.valid : f_res.valid));
    end
  endtask : t_route

  // Issues both channels together on flash, on different and on the same module.
  task automatic t_dual();
    core_inst.access(1'b1, 24'hc0_0000, 1'b0, 1'b1, 24'hc4_1230, 1'b1, 1'b0);
    chk("f mod", 24'h0, 24'(f_res.flash_mod));
    chk("d mod", 24'h1, 24'(d_res.flash_mod));
    chk("d line", 24'h0c_4123, 24'(d_res.flash_line));
    chk("both valid", 24'h3, 24'({f_res.valid, d_res.valid}));
    chk("word", 24'h1, 24'({f_res.word, d_res.word}));
    chk("clash", 24'h0, 24'(fl_clash));
    core_inst.access(1'b1, 24'hc4_0000, 1'b1, 1'b1, 24'hc7_fff0, 1'b0, 1'b0);
    chk("clash", 24'h1, 24'(fl_clash));
    chk("word", 24'h2, 24'({f_res.word, d_res.word}));
  endtask : t_dual

  // One data access judged on its reject flag and the write copy.
  task automatic prot_case(input logic [23:0] a, input logic wr, input logic exp);
    core_inst.access(1'b0, 24'h0, 1'b0, 1'b1, a, 1'b1, wr);
    chk("reject", 24'(exp), 24'(d_res.reject));
    chk("write copy", 24'(wr), 24'(d_write_q));
  endtask : prot_case

  // Program sram and flash write and read protection.
  task automatic t_prot();
    @(negedge sys_clk);
    ps_wp_en = 1'b1;
    fl_wp_mask[16] = 1'b1;
    prot_case(24'he0_00ff, 1'b1, 1'b1);
    prot_case(24'he0_0100, 1'b1, 1'b0);
    prot_case(24'he8_0000, 1'b1, 1'b1);
    prot_case(24'he0_0000, 1'b0, 1'b0);
    prot_case(24'hc0_f000, 1'b1, 1'b1);
    prot_case(24'hc0_e000, 1'b1, 1'b0);
    prot_case(24'hc4_0000, 1'b1, 1'b1);
    prot_case(24'hc4_4000, 1'b1, 1'b0);
    @(negedge sys_clk);
    ps_wp_en = 1'b0;
    fl_rp_en = 1'b1;
    prot_case(24'he0_0000, 1'b1, 1'b0);
    prot_case(24'hc8_0000, 1'b0, 1'b1);
    prot_case(24'hc0_1000, 1'b0, 1'b1);
    core_inst.access(1'b1, 24'hc8_0000, 1'b1, 1'b0, 24'h0, 1'b0, 1'b0);
    chk("fetch reject", 24'h0, 24'(f_res.reject));
    @(negedge sys_clk);
    fl_unlock = 1'b1;
    prot_case(24'hc8_0000, 1'b0, 1'b0);
  endtask : t_prot

  // Register bank hits and bit addressable places, bank based at 00_fc00.
  task automatic t_gpr();
    logic [23:0] a [5] = '{24'h00_fc06, 24'h00_fc13, 24'h00_fc12, 24'h00_fc20, 24'h00_f600};
    logic [4:0] wd = 5'b01100;
    logic [4:0] hit = 5'b00101;
    logic [4:0] bok = 5'b00111;
    logic [3:0] idx [5] = '{4'h3, 4'h0, 4'h9, 4'h0, 4'h0};
    for (int i = 0; i < 5; i++)
    begin
      core_inst.access(1'b0, 24'h0, 1'b0, 1'b1, a[i], wd[i], 1'b0);
      chk("bank hit", 24'(hit[i]), 24'(d_res.bank_hit));
      if (hit[i])
        chk("bank idx", 24'(idx[i]), 24'(d_res.bank_idx));
      chk("bit ok", 24'(bok[i]), 24'(d_res.bit_ok));
    end
    core_inst.access(1'b0, 24'h0, 1'b0, 1'b1, 24'h00_fd00, 1'b0, 1'b0);
    chk("bit ok", 24'h1, 24'(d_res.bit_ok));
  endtask : t_gpr

  // Reset in mid-run clears every result.
  task automatic t_reset();
    @(negedge sys_clk);
    rst = 1'b1;
    core_inst.access(1'b1, 24'hc0_0000, 1'b1, 1'b1, 24'h20_0010, 1'b1, 1'b1);
    chk("reset out", 24'h0, 24'({f_res, d_res, d_write_q, fl_clash} != '0));
    rst = 1'b0;
  endtask : t_reset

  // ************************************************************
  // Main sequence and watchdog.
  // ************************************************************
  initial
  begin
    repeat (2) @(negedge sys_clk);
    chk("reset out", 24'h0, 24'({f_res, d_res, d_write_q, fl_clash} != '0));
    rst = 1'b0;
    t_map();
    t_route();
    t_dual();
    t_prot();
    t_gpr();
    t_reset();
    t_dual();
    end_sim();
  end

  initial
  begin
    #100000;
    failures++;
    $display("BAD watchdog expected done seen hang");
    end_sim();
  end
endmodule : testbench

/* File: tb/umm_core_model.sv */
// Model of the core fetch and data units that feed the decoder.
module umm_core_model (
  // Clock.
  input wire logic sys_clk,
  // Fetch channel.
  output logic f_req,
  output logic [umm_pkg::ADDR_W-1:0] f_addr,
  output logic f_word,
  // Data channel.
  output logic d_req,
  output logic [umm_pkg::ADDR_W-1:0] d_addr,
  output logic d_word,
  output logic d_write
);
  timeunit 1ns;
  timeprecision 1ps;
  import umm_pkg::*;

  // Both channels idle at time zero.
  initial
  begin
    {f_req, f_addr, f_word} = '0;
    {d_req, d_addr, d_word, d_write} = '0;
  end

  // One access per chosen channel, launched at a falling edge and held one cycle.
  // requests carry no data
  task automatic access(input logic fr, input logic [23:0] fa, input logic fw, input logic dr,
                        input logic [23:0] da, input logic dw, input logic wr);
    @(negedge sys_clk);
    {f_req, f_addr, f_word} = {fr, fa, fw};
    {d_req, d_addr, d_word, d_write} = {dr, da, dw, wr};
    @(negedge sys_clk);
    // Released lines show the inverse so a stale value cannot match by chance.
    {f_req, f_addr, f_word} = {1'b0, ~fa, ~fw};
    {d_req, d_addr, d_word, d_write} = {1'b0, ~da, ~dw, ~wr};
  endtask : access
endmodule : umm_core_model
